// >>> intc_ext_edge.v
// Purpose: interrupt controller with external edge pin, two timers, time base
// Assumes: core gives phase pulse, instruction-boundary and next pc
// Notes: register port has one-cycle read latency
`timescale 1ns/1ps
`default_nettype none
`include "intc_consts.vh"
module intc_ext_edge (
   input wire ref_clk,
   input wire rst,
   input wire [1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdData,
   input wire sharedExtIrqPin,
   input wire portADirection,
   input wire pullHighSel,
   input wire timer0Ovf,
   input wire timer1Ovf,
   input wire timebaseOvf,
   input wire secondPhasePulse,
   input wire instrBoundary,
   input wire wakeUp,
   input wire returnFromInterrupt,
   input wire [`INTC_PC_W-1:0] nextPc,
   output reg pcLoad,
   output reg [`INTC_PC_W-1:0] pcLoadValue,
   output reg stackPush,
   output reg stackPop,
   output reg [`INTC_PC_W-1:0] stackPushData,
   output reg [`INTC_SP_W-1:0] stackLevel,
   output reg pullHighEn
);
   localparam ST_RUN = 2'h0;
   localparam ST_PEND = 2'h1;
   localparam ST_WAKE = 2'h2;
   reg [1:0] state;
   reg [1:0] wakeCnt;
   reg [2:0] srcSel;
   reg globalIrqEnable;
   reg extIrqEnable;
   reg timer0IrqEnable;
   reg timer1IrqEnable;
   reg timebaseIrqEnable;
   reg extIrqFlag;
   reg timer0IrqFlag;
   reg timer1IrqFlag;
   reg timebaseIrqFlag;
   reg extEdgeSelHigh;
   reg extEdgeSelLow;
   reg pinSync1;
   reg pinSync2;
   reg pinPrev;
   wire riseEdge = pinSync2 & ~pinPrev;
   wire fallEdge = ~pinSync2 & pinPrev;
   // the second stage and its delayed copy pinPrev feed detection
   wire extEvent = (extEdgeSelLow & riseEdge) | (extEdgeSelHigh & fallEdge);
   wire stackFull = (stackLevel == `INTC_STACK_DEPTH);
   wire [3:0] ready = {timebaseIrqFlag & timebaseIrqEnable, timer1IrqFlag & timer1IrqEnable,
                       timer0IrqFlag & timer0IrqEnable, extIrqFlag & extIrqEnable};
   wire canTake = globalIrqEnable & ~stackFull & (|ready);
   reg [2:0] next_srcSel;
   always @* begin
      // fixed priority, external first
      if (ready[0]) next_srcSel = 3'h1;
      else if (ready[1]) next_srcSel = 3'h2;
      else if (ready[2]) next_srcSel = 3'h3;
      else next_srcSel = 3'h4;
   end
   // service issued at instruction boundary following the phase pulse
   wire fire = (state == ST_PEND) & instrBoundary;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
         pinPrev <= 1'b0;
      end else begin
         pinSync1 <= sharedExtIrqPin;
         pinSync2 <= pinSync1;
         pinPrev <= pinSync2;
      end
   end
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= ST_RUN;
         wakeCnt <= 2'h0;
         srcSel <= 3'h0;
         globalIrqEnable <= 1'b0;
         extIrqEnable <= 1'b0;
         timer0IrqEnable <= 1'b0;
         timer1IrqEnable <= 1'b0;
         timebaseIrqEnable <= 1'b0;
         extIrqFlag <= 1'b0;
         timer0IrqFlag <= 1'b0;
         timer1IrqFlag <= 1'b0;
         timebaseIrqFlag <= 1'b0;
         extEdgeSelHigh <= 1'b0;
         extEdgeSelLow <= 1'b0;
         pcLoad <= 1'b0;
         pcLoadValue <= {`INTC_PC_W{1'b0}};
         stackPush <= 1'b0;
         stackPop <= 1'b0;
         stackPushData <= {`INTC_PC_W{1'b0}};
         stackLevel <= {`INTC_SP_W{1'b0}};
         regRdData <= 8'h00;
         pullHighEn <= 1'b0;
      end else begin
         pcLoad <= 1'b0;
         stackPush <= 1'b0;
         stackPop <= 1'b0;
         regRdData <= 8'h00;
         pullHighEn <= pullHighSel;
         if (regWr) begin
            // software writes first so hardware sets below win
            case (regAddr)
               `INTC_ADDR_FIRST: begin
                  globalIrqEnable <= regWrData[`INTC_B_GIE];
                  extIrqEnable <= regWrData[`INTC_B_EXTE];
                  timer0IrqEnable <= regWrData[`INTC_B_T0E];
                  timer1IrqEnable <= regWrData[`INTC_B_T1E];
                  extIrqFlag <= regWrData[`INTC_B_EXTF];
                  timer0IrqFlag <= regWrData[`INTC_B_T0F];
                  timer1IrqFlag <= regWrData[`INTC_B_T1F];
               end
               `INTC_ADDR_SECOND: begin
                  timebaseIrqEnable <= regWrData[`INTC_B2_TBE];
                  timebaseIrqFlag <= regWrData[`INTC_B2_TBF];
               end
               `INTC_ADDR_MISC: begin
                  extEdgeSelHigh <= regWrData[`INTC_B_EDGE_HI];
                  extEdgeSelLow <= regWrData[`INTC_B_EDGE_LO];
               end
               default: ;
            endcase
         end
         if (regRd) begin
            case (regAddr)
               `INTC_ADDR_FIRST: regRdData <= {1'b0, timer1IrqFlag, timer0IrqFlag, extIrqFlag,
                  timer1IrqEnable, timer0IrqEnable, extIrqEnable, globalIrqEnable};
               `INTC_ADDR_SECOND: regRdData <= {2'h0, timebaseIrqFlag, 3'h0,
                  timebaseIrqEnable, 1'b0};
               `INTC_ADDR_MISC: regRdData <= {extEdgeSelHigh, extEdgeSelLow, 6'h00};
               `INTC_ADDR_STATUS: regRdData <= {portADirection, stackFull, state, 1'b0,
                  stackLevel};
               default: regRdData <= 8'h00;
            endcase
         end
         case (state)
            ST_RUN: begin
               if (wakeUp & canTake) begin
                  state <= ST_WAKE;
                  wakeCnt <= 2'h1;
               end else if (secondPhasePulse & canTake) begin
                  state <= ST_PEND;
                  srcSel <= next_srcSel;
               end
            end
            ST_WAKE: begin
               if (secondPhasePulse) begin
                  if (wakeCnt == `INTC_WAKE_CYC - 2'h1) begin
                     state <= ST_PEND;
                     srcSel <= next_srcSel;
                  end else wakeCnt <= wakeCnt + 2'h1;
               end
            end
            ST_PEND: begin
               if (fire) begin
                  state <= ST_RUN;
                  stackPush <= 1'b1;
                  stackPushData <= nextPc;
                  stackLevel <= stackLevel + 3'h1;
                  pcLoad <= 1'b1;
                  globalIrqEnable <= 1'b0;
                  case (srcSel)
                     3'h1: begin
                        pcLoadValue <= `INTC_VEC_EXT;
                        extIrqFlag <= 1'b0;
                     end
                     3'h2: begin
                        pcLoadValue <= `INTC_VEC_TMR0;
                        timer0IrqFlag <= 1'b0;
                     end
                     3'h3: begin
                        pcLoadValue <= `INTC_VEC_TMR1;
                        timer1IrqFlag <= 1'b0;
                     end
                     default: begin
                        pcLoadValue <= `INTC_VEC_TB;
                        timebaseIrqFlag <= 1'b0;
                     end
                  endcase
               end
            end
            default: state <= ST_RUN;
         endcase
         if (returnFromInterrupt & ~fire & (stackLevel != 3'h0)) begin
            stackPop <= 1'b1;
            stackLevel <= stackLevel - 3'h1;
         end
         // hardware sets last: set beats clear in same cycle
         if (extEvent) begin
            extIrqFlag <= 1'b1;
         end
         if (timer0Ovf) begin
            timer0IrqFlag <= 1'b1;
         end
         if (timer1Ovf) begin
            timer1IrqFlag <= 1'b1;
         end
         if (timebaseOvf) begin
            timebaseIrqFlag <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> intc_consts.vh
// Purpose: constants for the interrupt controller
// Assumes: 8-bit control words, 11-bit program counter
// Notes: definitions only
`ifndef INTC_CONSTS_VH
`define INTC_CONSTS_VH
`define INTC_PC_W 11
`define INTC_SP_W 3
`define INTC_STACK_DEPTH 3'h6
`define INTC_VEC_EXT 11'h004
`define INTC_VEC_TMR0 11'h008
`define INTC_VEC_TMR1 11'h00c
`define INTC_VEC_TB 11'h014
`define INTC_B_GIE 0
`define INTC_B_EXTE 1
`define INTC_B_T0E 2
`define INTC_B_T1E 3
`define INTC_B_EXTF 4
`define INTC_B_T0F 5
`define INTC_B_T1F 6
`define INTC_B2_TBE 1
`define INTC_B2_TBF 5
`define INTC_B_EDGE_LO 6
`define INTC_B_EDGE_HI 7
`define INTC_ADDR_FIRST 2'h0
`define INTC_ADDR_SECOND 2'h1
`define INTC_ADDR_MISC 2'h2
`define INTC_ADDR_STATUS 2'h3
`define INTC_MASK_FIRST 8'h7f
`define INTC_MASK_SECOND 8'h22
`define INTC_MASK_MISC 8'hc0
`define INTC_WAKE_CYC 2'h3
`endif

// >>> intc_core_model.sv
// Purpose: core stand-in giving phase pulses, jump boundaries and next pc
// Assumes: one instruction every four system clocks
// Notes: boundary follows each phase pulse by one clock
`timescale 1ns/1ps
`default_nettype none
`include "intc_consts.vh"
module intc_core_model (
   input wire logic ref_clk,
   input wire logic rst,
   output var logic secondPhasePulse,
   output var logic instrBoundary,
   output var logic [`INTC_PC_W-1:0] nextPc
);
   logic [1:0] phase;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase <= 2'h0;
         secondPhasePulse <= 1'b0;
         instrBoundary <= 1'b0;
         nextPc <= 11'h020;
      end else begin
         phase <= phase + 2'h1;
         secondPhasePulse <= (phase == 2'h3);
         instrBoundary <= secondPhasePulse;
         if (secondPhasePulse) nextPc <= nextPc + 11'h001;
      end
   end
endmodule
`default_nettype wire

// >>> intc_ext_edge_sva.sv
// Purpose: port checker for the interrupt controller
// Assumes: single clock domain
// Notes: bound from the testbench
`timescale 1ns/1ps
`default_nettype none
module intc_ext_edge_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic instrBoundary,
   input wire logic returnFromInterrupt,
   input wire logic pullHighSel,
   input wire logic pcLoad,
   input wire logic [10:0] pcLoadValue,
   input wire logic stackPush,
   input wire logic stackPop,
   input wire logic [2:0] stackLevel,
   input wire logic pullHighEn
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_take;
      instrBoundary ##1 stackPush;
   endsequence
   property p_push_load; pcLoad |-> stackPush; endproperty
   a_push_load: assert property (p_push_load) else $error("load without push");
   property p_vector;
      pcLoad |-> pcLoadValue inside {11'h004, 11'h008, 11'h00c, 11'h014};
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector");
   property p_level; stackPush |-> stackLevel == $past(stackLevel) + 3'h1; endproperty
   a_level: assert property (p_level) else $error("push level wrong");
   property p_full; stackPush |-> $past(stackLevel) < 3'h6; endproperty
   a_full: assert property (p_full) else $error("push on full stack");
   property p_pop;
      returnFromInterrupt && stackLevel != 3'h0 |=> stackPop && stackLevel == $past(stackLevel) - 3'h1;
   endproperty
   a_pop: assert property (p_pop) else $error("return did not pop");
   property p_pull; ##1 pullHighEn == $past(pullHighSel); endproperty
   a_pull: assert property (p_pull) else $error("pull-high lost");
   property p_boundary; stackPush |-> $past(instrBoundary); endproperty
   a_boundary: assert property (p_boundary) else $error("jump off boundary");
   property p_nest; s_take |=> !stackPush [*8]; endproperty
   a_nest: assert property (p_nest) else $error("nested service");
endmodule
`default_nettype wire

// >>> test_interrupt_controller_ext_edge.sv
// Purpose: register-level tests of the interrupt controller
// Assumes: bench re-enables only after service settles
// Notes: core is modelled by intc_core_model
`timescale 1ns/1ps
`default_nettype none
`include "intc_consts.vh"
module test_interrupt_controller_ext_edge;
   logic ref_clk = 0, rst = 1, regWr = 0, regRd = 0, pin = 0, pullHighSel = 0;
   logic t0 = 0, t1 = 0, tb = 0, wakeUp = 0, rti = 0, spp, ib, pcLoad;
   logic [1:0] regAddr = 0;
   logic [7:0] regWrData = 0, regRdData, w0, w1;
   logic [10:0] nextPc, pcLoadValue;
   int err_count = 0, n_compared = 0;
   always #50 ref_clk = ~ref_clk;
   intc_core_model core (.ref_clk(ref_clk), .rst(rst), .secondPhasePulse(spp),
      .instrBoundary(ib), .nextPc(nextPc));
   intc_ext_edge DUT (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sharedExtIrqPin(pin),
      .portADirection(1'b1), .pullHighSel(pullHighSel), .timer0Ovf(t0), .timer1Ovf(t1),
      .timebaseOvf(tb), .secondPhasePulse(spp), .instrBoundary(ib), .wakeUp(wakeUp),
      .returnFromInterrupt(rti), .nextPc(nextPc), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
      .stackPush(), .stackPop(), .stackPushData(), .stackLevel(), .pullHighEn());
   task automatic chk(input logic [10:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk) begin regWr <= 1; regAddr <= a; regWrData <= d; end
      @(posedge ref_clk) regWr <= 0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge ref_clk) begin regRd <= 1; regAddr <= a; end
      @(posedge ref_clk) regRd <= 0;
      #1 chk({3'h0, regRdData}, {3'h0, e});
   endtask
   // 0 timer0, 1 timer1, 2 time base, else return
   task automatic pulse(input int k);
      @(posedge ref_clk);
      case (k)
         0: t0 <= 1;
         1: t1 <= 1;
         2: tb <= 1;
         default: rti <= 1;
      endcase
      @(posedge ref_clk);
      t0 <= 0;
      t1 <= 0;
      tb <= 0;
      rti <= 0;
   endtask
   // bounded wait; exp 0 means no service may happen
   task automatic svc(input logic [10:0] exp);
      for (int i = 0; i < 20; i++) begin
         @(posedge ref_clk) #1;
         if (pcLoad === 1'b1) begin chk(pcLoadValue, exp); repeat (10) @(posedge ref_clk); return; end
      end
      if (exp !== 11'h0) chk(11'h7ff, exp);
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      logic [10:0] vec [4] = '{11'h004, 11'h008, 11'h00c, 11'h014};
      repeat (12) @(posedge ref_clk);
      rst <= 0;
      rd(0, 8'h00); rd(1, 8'h00); rd(2, 8'h00);
      for (int s = 0; s < 4; s++) begin
         wr(2, {s[1:0], 6'h0});
         @(posedge ref_clk) pin <= 1;
         repeat (5) @(posedge ref_clk);
         rd(0, {3'h0, s[0], 4'h0});
         wr(0, 8'h00);
         @(posedge ref_clk) pin <= 0;
         repeat (5) @(posedge ref_clk);
         rd(0, {3'h0, s[1], 4'h0});
         wr(0, 8'h00);
      end
      $display("edge select test done");
      wr(0, 8'h0e); wr(1, 8'h02); pullHighSel <= 1;
      @(posedge ref_clk) pin <= 1;
      pulse(0); pulse(1); pulse(2);
      svc(11'h0);
      rd(0, 8'h7e); rd(1, 8'h22);
      wr(3, 8'hff); rd(0, 8'h7e);
      w0 = 8'h7f; w1 = 8'h22;
      for (int i = 0; i < 4; i++) begin
         wr(0, w0);
         svc(vec[i]);
         w0[0] = 0;
         if (i < 3) w0[4 + i] = 0; else w1[5] = 0;
         rd(0, w0); rd(1, w1);
         w0[0] = 1;
      end
      $display("priority test done");
      // four services above still sit on the stack
      repeat (4) pulse(3);
      for (int i = 0; i < 7; i++) begin
         pulse(0);
         wr(0, 8'h25);
         svc(i < 6 ? 11'h008 : 11'h0);
      end
      pulse(3);
      svc(11'h008);
      $display("stack test done");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      test_done();
   end
endmodule
bind intc_ext_edge intc_ext_edge_sva chk_i (.ref_clk(ref_clk), .rst(rst),
   .instrBoundary(instrBoundary), .returnFromInterrupt(returnFromInterrupt),
   .pullHighSel(pullHighSel), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
   .stackPush(stackPush), .stackPop(stackPop), .stackLevel(stackLevel), .pullHighEn(pullHighEn));
`default_nettype wire
